// ===== cqd_pkg.sv
// Constants, types and field layout of the completer request descriptor.
// Functional notes
// - Region number in bits 114:112 for mem/IO/atomic.
// - Sixty-four-bit pair hits report the lower, even number.
// - Six-bit aperture exponent in bits 120:115.
// - Function regions use one function's size.
// - Traffic class in bits 123:121.
// - Attributes 126:124; ID ordering cleared only for IO requests.
// - LTR latencies into bits 15:0 and 31:16.
// - OBFF code into bits 35:32.
// - Message code into bits 111:104.
// - Message routing into bits 114:112.
// - Vendor message routed by ID: destination 15:0.
// - Vendor message header dword three into 63:32.
// - ATS header dwords two, three into 63:0.
// - Memory, IO and atomic type codes 0000-0110.
// - Locked read 0111 only for legacy devices.
// - Configuration codes never leave on this stream.
// - Messages 1100, vendor 1101, ATS 1110; 1111 reserved.
// - Request type code in bits 78:75.
// - Sixteen-byte descriptor: two beats narrow, one wide.
package cqd_pkg;

	localparam int DESC_W      = 128;
	localparam int DW_W        = 32;
	// ===========================================================
	// Field positions
	// ===========================================================
	localparam int AT_LO       = 0;
	localparam int AT_HI       = 1;
	localparam int ADDR_LO     = 2;
	localparam int ADDR_HI     = 63;
	localparam int CNT_LO      = 64;
	localparam int CNT_HI      = 74;
	localparam int TYPE_LO     = 75;
	localparam int TYPE_HI     = 78;
	localparam int RID_LO      = 80;
	localparam int RID_HI      = 95;
	localparam int TAG_LO      = 96;
	localparam int TAG_HI      = 103;
	localparam int FN_LO       = 104;
	localparam int FN_HI       = 111;
	localparam int REGION_LO   = 112;
	localparam int REGION_HI   = 114;
	localparam int APER_LO     = 115;
	localparam int APER_HI     = 120;
	localparam int CLASS_LO    = 121;
	localparam int CLASS_HI    = 123;
	localparam int ATTR_LO     = 124;
	localparam int ATTR_HI     = 126;
	localparam int SNOOP_LO    = 0;
	localparam int SNOOP_HI    = 15;
	localparam int NOSNOOP_LO  = 16;
	localparam int NOSNOOP_HI  = 31;
	localparam int OBFF_LO     = 32;
	localparam int OBFF_HI     = 35;
	localparam int DW3_LO      = 32;
	localparam int DW3_HI      = 63;
	localparam int ATTR_IDO    = 2;

	// ===========================================================
	// Codes
	// ===========================================================
	localparam logic [3:0] TYPE_MEM_RD  = 4'h0;
	localparam logic [3:0] TYPE_MEM_WR  = 4'h1;
	localparam logic [3:0] TYPE_IO_RD   = 4'h2;
	localparam logic [3:0] TYPE_IO_WR   = 4'h3;
	localparam logic [3:0] TYPE_FADD    = 4'h4;
	localparam logic [3:0] TYPE_SWAP    = 4'h5;
	localparam logic [3:0] TYPE_CAS     = 4'h6;
	localparam logic [3:0] TYPE_LOCK_RD = 4'h7;
	localparam logic [3:0] TYPE_CFG0_RD = 4'h8;
	localparam logic [3:0] TYPE_MSG     = 4'hc;
	localparam logic [3:0] TYPE_VDM     = 4'hd;
	localparam logic [3:0] TYPE_ATS     = 4'he;
	localparam logic [2:0] ROUTE_BY_ID  = 3'h2;
	localparam logic [3:0] OBFF_ACTIVE  = 4'hf;
	localparam logic [3:0] OBFF_MEMPATH = 4'h1;
	localparam logic [3:0] OBFF_IDLE    = 4'h0;
	localparam int         NUM_REGIONS  = 6;
	localparam logic [2:0] ROM_CODE     = 3'h6;

	typedef enum logic [3:0] {
		CQD_MEM_RD, CQD_MEM_WR, CQD_IO_RD, CQD_IO_WR, CQD_FADD, CQD_SWAP, CQD_CAS,
		CQD_LOCK_RD, CQD_CFG, CQD_MSG_LTR, CQD_MSG_OBFF, CQD_MSG_GEN, CQD_MSG_VDM,
		CQD_MSG_ATS
	} cqd_kind_t;

	// Parsed request header fields, as handed over by the transaction layer.
	typedef struct packed {
		cqd_kind_t    kind;
		logic [1:0]   at;
		logic [63:2]  addr;
		logic [10:0]  dw_count;
		logic [15:0]  req_id;
		logic [7:0]   tag;
		logic [7:0]   target_fn;
		logic [2:0]   traffic_class_field;
		logic [2:0]   attr;
		logic [6:0]   hit_vec;
		logic         hit_vf;
		logic [5:0]   region_size_log2;
		logic [5:0]   vf_count_log2;
		logic [7:0]   msg_code;
		logic [2:0]   msg_route;
		logic [31:0]  hdr_dw2;
		logic [31:0]  hdr_dw3;
		logic         has_payload;
	} cqd_req_t;

endpackage

// ===== cqd_region_enc.sv
// Encodes a one-hot region hit into the reported region number.
`timescale 1ns/1ns
module cqd_region_enc #(
	parameter logic [5:0] PAIR64 = 6'h00
) (
	input  wire logic [6:0] hit_vec,
	output logic      [2:0] region_hit_number
);
	// Bit 6 of the hit vector is the expansion ROM; bits 5:0 the regions.
	// PAIR64 bit k set, for even k, means regions k and k+1 form one 64-bit pair.
	logic [2:0] raw;

	always_comb begin
		raw = 3'h0;
		for (int i = cqd_pkg::NUM_REGIONS - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				raw = 3'(i);
			end
		end
	end

	// Upper half of a pair folds down to the lower, even number.
	wire upper_of_pair = raw[0] && PAIR64[raw - 3'h1];

	assign region_hit_number = hit_vec[cqd_pkg::NUM_REGIONS] ? cqd_pkg::ROM_CODE
		: upper_of_pair ? {raw[2:1], 1'b0} : raw;

endmodule // cqd_region_enc

// ===== cqd_aperture.sv
// Computes the aperture exponent reported with a region hit.
`timescale 1ns/1ns
module cqd_aperture (
	input  wire logic [5:0] region_size_log2,
	input  wire logic       hit_vf,
	input  wire logic [5:0] vf_count_log2,
	output logic      [5:0] aperture
);
	// A function region is split evenly among its functions, so one
	// function's share is the total divided by the function count.
	wire [5:0] per_vf = (vf_count_log2 > region_size_log2) ? 6'h0
		: region_size_log2 - vf_count_log2;

	assign aperture = hit_vf ? per_vf : region_size_log2;

endmodule // cqd_aperture

// ===== cqd_desc_framer.sv
// Builds the completer request descriptor and sends it as the packet head.
`timescale 1ns/1ns
module cqd_desc_framer #(
	parameter int         DATA_W = 128,
	parameter bit         LEGACY = 1'b0,
	parameter logic [5:0] PAIR64 = 6'h00
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire cqd_pkg::cqd_req_t      req,
	input  wire logic                   req_valid,
	output logic                        req_ready,
	output logic                        req_dropped,
	output logic [DATA_W-1:0]           cq_tdata,
	output logic [DATA_W/32-1:0]        cq_tkeep,
	output logic                        cq_tvalid,
	output logic                        cq_tlast,
	output logic                        cq_sop,
	input  wire logic                   cq_tready,
	output logic                        desc_done
);
	localparam int  KEEP_W  = DATA_W / 32;
	localparam int  BEATS   = (DATA_W == 64) ? 2 : 1;
	localparam int  DESC_DW = cqd_pkg::DESC_W / cqd_pkg::DW_W;

	typedef enum logic [1:0] {CQD_IDLE, CQD_BEAT0, CQD_BEAT1} cqd_state_t;

	// ===========================================================
	// Type encoding and classification
	// ===========================================================
	function automatic logic [3:0] type_code(input cqd_pkg::cqd_kind_t k);
		unique case (k)
			cqd_pkg::CQD_MEM_RD:   type_code = cqd_pkg::TYPE_MEM_RD;
			cqd_pkg::CQD_MEM_WR:   type_code = cqd_pkg::TYPE_MEM_WR;
			cqd_pkg::CQD_IO_RD:    type_code = cqd_pkg::TYPE_IO_RD;
			cqd_pkg::CQD_IO_WR:    type_code = cqd_pkg::TYPE_IO_WR;
			cqd_pkg::CQD_FADD:     type_code = cqd_pkg::TYPE_FADD;
			cqd_pkg::CQD_SWAP:     type_code = cqd_pkg::TYPE_SWAP;
			cqd_pkg::CQD_CAS:      type_code = cqd_pkg::TYPE_CAS;
			cqd_pkg::CQD_LOCK_RD:  type_code = cqd_pkg::TYPE_LOCK_RD;
			cqd_pkg::CQD_CFG:      type_code = cqd_pkg::TYPE_CFG0_RD;
			cqd_pkg::CQD_MSG_VDM:  type_code = cqd_pkg::TYPE_VDM;
			cqd_pkg::CQD_MSG_ATS:  type_code = cqd_pkg::TYPE_ATS;
			cqd_pkg::CQD_MSG_LTR,
			cqd_pkg::CQD_MSG_OBFF,
			cqd_pkg::CQD_MSG_GEN:  type_code = cqd_pkg::TYPE_MSG;
			default:               type_code = cqd_pkg::TYPE_MSG;
		endcase
	endfunction

	function automatic logic is_msg(input cqd_pkg::cqd_kind_t k);
		is_msg = (k >= cqd_pkg::CQD_MSG_LTR);
	endfunction

	function automatic logic is_io(input cqd_pkg::cqd_kind_t k);
		is_io = (k == cqd_pkg::CQD_IO_RD) || (k == cqd_pkg::CQD_IO_WR);
	endfunction

	// ===========================================================
	// Region number and aperture
	// ===========================================================
	logic [2:0] region_hit_number;
	logic [5:0] aperture;

	cqd_region_enc #(
		.PAIR64            (PAIR64)
	) u_region (
		.hit_vec           (req.hit_vec),
		.region_hit_number (region_hit_number)
	);

	cqd_aperture u_aper (
		.region_size_log2 (req.region_size_log2),
		.hit_vf           (req.hit_vf),
		.vf_count_log2    (req.vf_count_log2),
		.aperture         (aperture)
	);

	// ===========================================================
	// Descriptor assembly
	// ===========================================================
	wire msg       = is_msg(req.kind);
	wire io        = is_io(req.kind);
	wire mem_class = !msg && (req.kind != cqd_pkg::CQD_CFG);
	wire mem_atom  = mem_class && !io;
	wire is_ltr    = (req.kind == cqd_pkg::CQD_MSG_LTR);
	wire is_obff   = (req.kind == cqd_pkg::CQD_MSG_OBFF);
	wire is_vdm    = (req.kind == cqd_pkg::CQD_MSG_VDM);
	wire is_ats    = (req.kind == cqd_pkg::CQD_MSG_ATS);
	wire vdm_by_id = is_vdm && (req.msg_route == cqd_pkg::ROUTE_BY_ID);

	// Configuration requests belong to the requester side, and a locked read
	// is only legal when the device is built as a legacy endpoint.
	wire illegal = (req.kind == cqd_pkg::CQD_CFG)
		|| ((req.kind == cqd_pkg::CQD_LOCK_RD) && !LEGACY);

	// ID-based ordering is cleared for I/O requests.
	wire [2:0] attr_out = io ? (req.attr & ~(3'h1 << cqd_pkg::ATTR_IDO)) : req.attr;

	wire [2:0] region_or_route = msg ? req.msg_route : region_hit_number;
	wire [7:0] fn_or_code      = msg ? req.msg_code : req.target_fn;
	wire [5:0] aper_field      = mem_class ? aperture : 6'h0;
	wire [1:0] at_field        = mem_atom ? req.at : 2'h0;

	logic [63:0] low_half;

	always_comb begin
		low_half = 64'h0;
		if (mem_class) begin
			low_half[cqd_pkg::ADDR_HI:cqd_pkg::ADDR_LO] = req.addr;
			low_half[cqd_pkg::AT_HI:cqd_pkg::AT_LO]     = at_field;
		end else if (is_ltr) begin
			low_half[cqd_pkg::SNOOP_HI:cqd_pkg::SNOOP_LO]     = req.hdr_dw3[15:0];
			low_half[cqd_pkg::NOSNOOP_HI:cqd_pkg::NOSNOOP_LO] = req.hdr_dw3[31:16];
		end else if (is_obff) begin
			low_half[cqd_pkg::OBFF_HI:cqd_pkg::OBFF_LO] = req.hdr_dw3[3:0];
		end else if (is_vdm) begin
			low_half[cqd_pkg::DW3_HI:cqd_pkg::DW3_LO] = req.hdr_dw3;
			if (vdm_by_id) begin
				low_half[cqd_pkg::SNOOP_HI:cqd_pkg::SNOOP_LO] = req.hdr_dw2[31:16];
			end
		end else if (is_ats) begin
			low_half = {req.hdr_dw3, req.hdr_dw2};
		end
	end

	wire [cqd_pkg::DESC_W-1:0] desc_d = {
		1'b0,
		attr_out,
		req.traffic_class_field,
		aper_field,
		region_or_route,
		fn_or_code,
		req.tag,
		req.req_id,
		1'b0,
		type_code(req.kind),
		req.dw_count,
		low_half
	};

	// ===========================================================
	// Beat sequencing
	// ===========================================================
	cqd_state_t                state_q;
	cqd_state_t                state_d;
	logic [cqd_pkg::DESC_W-1:0] desc_q;
	logic                      payload_q;
	logic                      dropped_q;

	wire take     = req_valid && req_ready;
	wire accept   = take && !illegal;
	wire beat_go  = cq_tvalid && cq_tready;
	wire last_beat = (BEATS == 1) ? (state_q == CQD_BEAT0) : (state_q == CQD_BEAT1);

	// A new request is taken only once the previous descriptor has left.
	assign req_ready = (state_q == CQD_IDLE);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CQD_IDLE: begin
				if (accept) begin
					state_d = CQD_BEAT0;
				end
			end
			CQD_BEAT0: begin
				if (beat_go) begin
					state_d = (BEATS == 1) ? CQD_IDLE : CQD_BEAT1;
				end
			end
			CQD_BEAT1: begin
				if (beat_go) begin
					state_d = CQD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q   <= CQD_IDLE;
			desc_q    <= '0;
			payload_q <= 1'b0;
			dropped_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			dropped_q <= take && illegal;
			if (accept) begin
				desc_q    <= desc_d;
				payload_q <= req.has_payload;
			end
		end
	end

	// ===========================================================
	// Stream outputs
	// ===========================================================
	logic [DATA_W-1:0]       beat_data;
	logic [KEEP_W-1:0]       beat_keep;

	// Each width gets its own selection, so no slice ever reaches past the bus.
	if (DATA_W == 64) begin : g_narrow
		// The narrow stream carries the low half first, then the high half.
		assign beat_data = (state_q == CQD_BEAT1) ? desc_q[cqd_pkg::DESC_W-1:DATA_W]
			: desc_q[DATA_W-1:0];
		assign beat_keep = '1;
	end else begin : g_wide
		assign beat_data = DATA_W'(desc_q);
		assign beat_keep = KEEP_W'({DESC_DW{1'b1}});
	end

	assign cq_tvalid   = (state_q != CQD_IDLE);
	assign cq_tdata    = cq_tvalid ? beat_data : '0;
	assign cq_tkeep    = cq_tvalid ? beat_keep : '0;
	assign cq_sop      = (state_q == CQD_BEAT0);
	assign cq_tlast    = last_beat && !payload_q;
	assign desc_done   = beat_go && last_beat;
	assign req_dropped = dropped_q;

endmodule // cqd_desc_framer

// ===== cqd_desc_framer_sva.sv
// Concurrent checks on the descriptor framer ports.
`timescale 1ns/1ns
module cqd_checker #(
	parameter int DATA_W = 128,
	parameter bit LEGACY = 1'b0
) (
	input wire logic                clock,
	input wire logic                rst,
	input wire cqd_pkg::cqd_req_t   req,
	input wire logic                req_valid,
	input wire logic                req_ready,
	input wire logic                req_dropped,
	input wire logic [DATA_W-1:0]   cq_tdata,
	input wire logic [DATA_W/32-1:0] cq_tkeep,
	input wire logic                cq_tvalid,
	input wire logic                cq_tlast,
	input wire logic                cq_sop,
	input wire logic                cq_tready,
	input wire logic                desc_done
);
	logic take;
	logic bad;
	assign take = req_valid && req_ready;
	assign bad = req.kind == cqd_pkg::CQD_CFG || (req.kind == cqd_pkg::CQD_LOCK_RD && !LEGACY);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_take; take && !bad |=> cq_tvalid && cq_sop && !req_ready; endproperty
	a_take: assert property (p_take) else $error("legal request gave no beat");
	property p_drop; take && bad |=> req_dropped && !cq_tvalid; endproperty
	a_drop: assert property (p_drop) else $error("illegal request not dropped");
	property p_hold; cq_tvalid && !cq_tready |=> cq_tvalid && $stable(cq_tdata); endproperty
	a_hold: assert property (p_hold) else $error("beat changed while stalled");
	property p_type; cq_tvalid |-> !(cq_tdata[78:75] inside {[4'h8:4'hb], 4'hf}); endproperty
	a_type: assert property (p_type) else $error("forbidden request type");
	property p_class; take && !bad |=> cq_tdata[123:121] == $past(req.traffic_class_field);
	endproperty
	a_class: assert property (p_class) else $error("traffic class wrong");
	property p_ido; cq_tvalid && cq_tdata[78:76] == 3'h1 |-> !cq_tdata[126]; endproperty
	a_ido: assert property (p_ido) else $error("id ordering set on io");
	property p_msg; take && req.kind == cqd_pkg::CQD_MSG_GEN |=> cq_tdata[78:75] == 4'hc &&
		cq_tdata[114:104] == {$past(req.msg_route), $past(req.msg_code)}; endproperty
	a_msg: assert property (p_msg) else $error("message fields wrong");
	property p_done; cq_tvalid && cq_tready |-> desc_done ##1 (req_ready && !cq_tvalid); endproperty
	a_done: assert property (p_done) else $error("descriptor not one beat");
	property p_zero; cq_tvalid |-> !cq_tdata[127] && !cq_tdata[79] && cq_tkeep[3:0] == 4'hf;
	endproperty
	a_zero: assert property (p_zero) else $error("spare bits or keep wrong");
endmodule // cqd_checker
bind cqd_desc_framer cqd_checker #(.DATA_W(DATA_W), .LEGACY(LEGACY)) i_chk (.clock(clock),
	.rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
	.req_dropped(req_dropped), .cq_tdata(cq_tdata), .cq_tkeep(cq_tkeep), .cq_tvalid(cq_tvalid),
	.cq_tlast(cq_tlast), .cq_sop(cq_sop), .cq_tready(cq_tready), .desc_done(desc_done));

// ===== cqd_sink.sv
// Completer-side sink that accepts descriptor beats, stalling on request.
`timescale 1ns/1ns
module cqd_sink (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         slow,
	input  wire logic         cq_tvalid,
	input  wire logic [127:0] cq_tdata,
	output logic              cq_tready,
	output logic [5:0]        kept_q
);
	logic [1:0] cnt_q;
	logic       np;
	// Memory reads, io and atomics expect a completion, so class and attributes are kept.
	assign np = cq_tdata[78:75] inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
	always_ff @(posedge clock) begin
		cnt_q <= rst ? 2'h0 : cnt_q + 2'h1;
		if (cq_tvalid && cq_tready && np)
			kept_q <= cq_tdata[126:121];
	end
	// Accepts one cycle in four when slow.
	assign cq_tready = !slow || cnt_q == 2'h3;
endmodule // cqd_sink

// ===== tb_top.sv
// Directed testbench for the descriptor framer.
`timescale 1ns/1ns
module tb_top;
	logic              clock = 0;
	logic              rst = 1;
	logic              req_valid = 0;
	logic              slow = 0;
	cqd_pkg::cqd_req_t req = '0;
	cqd_pkg::cqd_req_t r;
	logic              req_ready, req_dropped, cq_tvalid, cq_tlast, cq_sop, cq_tready, desc_done;
	logic [127:0]      cq_tdata;
	logic [3:0]        cq_tkeep;
	logic              l_tvalid, l_dropped;
	logic [127:0]      l_tdata;
	logic [5:0]        kept;
	int                num_errors = 0;
	int                samples_checked = 0;
	initial forever #4 clock = ~clock;
	cqd_desc_framer #(.DATA_W(128), .PAIR64(6'h01)) i_dut (.clock(clock), .rst(rst), .req(req),
		.req_valid(req_valid), .req_ready(req_ready), .req_dropped(req_dropped),
		.cq_tdata(cq_tdata), .cq_tkeep(cq_tkeep), .cq_tvalid(cq_tvalid), .cq_tlast(cq_tlast),
		.cq_sop(cq_sop), .cq_tready(cq_tready), .desc_done(desc_done));
	// A second framer built as a legacy endpoint, which must pass locked reads.
	cqd_desc_framer #(.DATA_W(128), .LEGACY(1'b1), .PAIR64(6'h01)) i_dut_legacy (.clock(clock),
		.rst(rst), .req(req), .req_valid(req_valid), .req_ready(), .req_dropped(l_dropped),
		.cq_tdata(l_tdata), .cq_tkeep(), .cq_tvalid(l_tvalid), .cq_tlast(), .cq_sop(),
		.cq_tready(1'b1), .desc_done());
	cqd_sink i_sink (.clock(clock), .rst(rst), .slow(slow), .cq_tvalid(cq_tvalid),
		.cq_tdata(cq_tdata), .cq_tready(cq_tready), .kept_q(kept));
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch time=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic [127:0] fm(cqd_pkg::cqd_req_t q, logic [3:0] ty, logic [2:0] rg,
		logic [5:0] ap);
		logic io;
		io = ty[3:1] == 3'h1;
		return {1'b0, q.attr[2] & !io, q.attr[1:0], q.traffic_class_field, ap, rg, q.target_fn,
			q.tag, q.req_id, 1'b0, ty, q.dw_count, q.addr, q.at & {2{!io}}};
	endfunction
	function automatic logic [127:0] fmsg(cqd_pkg::cqd_req_t q, logic [3:0] ty, logic [63:0] lo);
		return {1'b0, q.attr, q.traffic_class_field, 6'h00, q.msg_route, q.msg_code, q.tag,
			q.req_id, 1'b0, ty, q.dw_count, lo};
	endfunction
	// Presents one request and compares the descriptor beat it produces.
	task automatic go(input cqd_pkg::cqd_kind_t k, input cqd_pkg::cqd_req_t q,
		input logic [127:0] exp);
		int n;
		q.kind = k;
		@(negedge clock);
		req = q;
		req_valid = 1;
		@(negedge clock);
		req_valid = 0;
		if (k == cqd_pkg::CQD_CFG || k == cqd_pkg::CQD_LOCK_RD) begin
			chk({cq_tvalid, req_dropped}, 128'h1);
			chk(l_tvalid ? l_tdata : 128'(l_dropped), exp);
		end else begin
			n = 0;
			while (!(cq_tvalid && cq_tready) && n < 20) begin
				@(negedge clock);
				n++;
			end
			chk(cq_tdata, exp);
			chk({cq_sop, cq_tlast, desc_done, req_ready, cq_tkeep},
				{1'b1, !q.has_payload, 1'b1, 1'b0, 4'hf});
		end
		@(negedge clock);
	endtask
	initial begin
		#20000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		r = '0;
		r.at = 2'h2;
		r.addr = 62'h1234_5678_9abc_def;
		r.dw_count = 11'h100;
		r.req_id = 16'hbeef;
		r.tag = 8'h5a;
		r.target_fn = 8'h41;
		r.traffic_class_field = 3'h5;
		r.attr = 3'h7;
		r.hit_vec = 7'h02;
		r.region_size_log2 = 6'h0c;
		r.vf_count_log2 = 6'h04;
		r.msg_code = 8'h7e;
		r.msg_route = 3'h2;
		r.hdr_dw2 = 32'hcafe_f00d;
		r.hdr_dw3 = 32'h8765_4321;
		repeat (2) @(negedge clock);
		rst = 0;
		for (int k = 0; k < 7; k++) begin
			r.has_payload = k[0];
			slow = k[1];
			go(cqd_pkg::cqd_kind_t'(k[3:0]), r, fm(r, k[3:0], 3'h0, 6'h0c));
		end
		r.has_payload = 0;
		r.hit_vec = 7'h28;
		r.hit_vf = 1;
		go(cqd_pkg::CQD_MEM_RD, r, fm(r, 4'h0, 3'h3, 6'h08));
		r.hit_vec = 7'h60;
		r.hit_vf = 0;
		go(cqd_pkg::CQD_MEM_WR, r, fm(r, 4'h1, 3'h6, 6'h0c));
		r.hit_vec = 7'h20;
		go(cqd_pkg::CQD_MEM_RD, r, fm(r, 4'h0, 3'h5, 6'h0c));
		go(cqd_pkg::CQD_MSG_LTR, r, fmsg(r, 4'hc, {32'h0, r.hdr_dw3}));
		go(cqd_pkg::CQD_MSG_OBFF, r, fmsg(r, 4'hc, {28'h0, 4'h1, 32'h0}));
		go(cqd_pkg::CQD_MSG_GEN, r, fmsg(r, 4'hc, 64'h0));
		go(cqd_pkg::CQD_MSG_VDM, r, fmsg(r, 4'hd, {r.hdr_dw3, 16'h0, r.hdr_dw2[31:16]}));
		go(cqd_pkg::CQD_MSG_ATS, r, fmsg(r, 4'he, {r.hdr_dw3, r.hdr_dw2}));
		go(cqd_pkg::CQD_CFG, r, 128'h1);
		go(cqd_pkg::CQD_LOCK_RD, r, fm(r, 4'h7, 3'h5, 6'h0c));
		go(cqd_pkg::CQD_IO_RD, r, fm(r, 4'h2, 3'h5, 6'h0c));
		chk(kept, {3'h3, r.traffic_class_field});
		report_and_stop();
	end
endmodule // tb_top
